/* File: shared/dpsr_defines.svh */
// offsets, reset values and field positions of the page and scratch bank
`ifndef DPSR_DEFINES_SVH
`define DPSR_DEFINES_SVH
`define DPSR_OFF_SCRATCH1 8'h84
`define DPSR_OFF_SCRATCH2 8'h85
`define DPSR_OFF_SCRATCH3 8'h86
`define DPSR_OFF_CHAN0_PAGE 8'h87
`define DPSR_OFF_SCRATCH4 8'h88
`define DPSR_OFF_CHAN6_PAGE 8'h89
`define DPSR_OFF_CHAN7_PAGE 8'h8A
`define DPSR_OFF_CHAN5_PAGE 8'h8B
`define DPSR_RST_BYTE 8'h00
`define DPSR_PAGE_LSB 16
`endif

/* File: shared/dpsr_pkg.sv */
// types shared by the page and scratch bank
package dpsr_pkg;
   typedef logic [7:0] dpsr_byte_t;
   typedef logic [27:0] dpsr_addr_t;
   typedef logic [15:0] dpsr_low_t;
   typedef enum logic [1:0] {DPSR_CH0 = 2'h0, DPSR_CH5 = 2'h1, DPSR_CH6 = 2'h2,
      DPSR_CH7 = 2'h3} dpsr_chan_t;
endpackage

/* File: hw/dpsr_bank.sv */
// page and scratch register bank with DMA address formation
`timescale 1ns/1ps
`include "dpsr_defines.svh"
module dpsr_bank (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire dpsr_pkg::dpsr_byte_t io_addr,
   input wire dpsr_pkg::dpsr_byte_t io_wdata,
   output dpsr_pkg::dpsr_byte_t io_rdata,
   output logic io_hit,
   output logic ext_bus_wr,
   output dpsr_pkg::dpsr_byte_t ext_bus_addr,
   output dpsr_pkg::dpsr_byte_t ext_bus_data,
   input wire logic enhanced_mode_enable,
   input wire logic chan5_alternate_width,
   input wire logic chan6_alternate_width,
   input wire logic chan7_alternate_width,
   input wire dpsr_pkg::dpsr_chan_t dma_chan,
   input wire dpsr_pkg::dpsr_low_t dma_low_addr,
   input wire logic [3:0] dma_ext_page,
   input wire logic dma_cross,
   input wire logic dma_down,
   output dpsr_pkg::dpsr_addr_t dma_addr,
   output logic dma_byte_mode
);
   import dpsr_pkg::*;

   // ************************************************************
   // register storage
   // ************************************************************
   dpsr_byte_t scr1_ff, scr2_ff, scr3_ff, scr4_ff;
   dpsr_byte_t pg0_ff, pg5_ff, pg6_ff, pg7_ff;
   logic scr_hit, pg_hit, cur_byte;
   dpsr_byte_t cur_page, nxt_page, nxt_rdata;

   always_comb begin
      scr_hit = (io_addr == `DPSR_OFF_SCRATCH1) || (io_addr == `DPSR_OFF_SCRATCH2) ||
         (io_addr == `DPSR_OFF_SCRATCH3) || (io_addr == `DPSR_OFF_SCRATCH4);
      pg_hit = (io_addr == `DPSR_OFF_CHAN0_PAGE) || (io_addr == `DPSR_OFF_CHAN5_PAGE) ||
         (io_addr == `DPSR_OFF_CHAN6_PAGE) || (io_addr == `DPSR_OFF_CHAN7_PAGE);
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         scr1_ff <= `DPSR_RST_BYTE;
         scr2_ff <= `DPSR_RST_BYTE;
         scr3_ff <= `DPSR_RST_BYTE;
         scr4_ff <= `DPSR_RST_BYTE;
      end else if (io_wr) begin
         if (io_addr == `DPSR_OFF_SCRATCH1) scr1_ff <= io_wdata;
         if (io_addr == `DPSR_OFF_SCRATCH2) scr2_ff <= io_wdata;
         if (io_addr == `DPSR_OFF_SCRATCH3) scr3_ff <= io_wdata;
         if (io_addr == `DPSR_OFF_SCRATCH4) scr4_ff <= io_wdata;
      end
   end

   // ************************************************************
   // transfer width and page stepping
   // ************************************************************
   // ch0 always byte mode; ch5-ch7 word mode unless enhanced plus alternate width
   always_comb begin
      unique case (dma_chan)
         DPSR_CH0: cur_byte = 1'b1;
         DPSR_CH5: cur_byte = enhanced_mode_enable & chan5_alternate_width;
         DPSR_CH6: cur_byte = enhanced_mode_enable & chan6_alternate_width;
         DPSR_CH7: cur_byte = enhanced_mode_enable & chan7_alternate_width;
      endcase
      unique case (dma_chan)
         DPSR_CH0: cur_page = pg0_ff;
         DPSR_CH5: cur_page = pg5_ff;
         DPSR_CH6: cur_page = pg6_ff;
         DPSR_CH7: cur_page = pg7_ff;
      endcase
      // carry by 1 in byte mode, by 2 in word mode so bit 0 is kept
      if (dma_down) begin
         nxt_page = cur_page - (cur_byte ? 8'h01 : 8'h02);
      end else begin
         nxt_page = cur_page + (cur_byte ? 8'h01 : 8'h02);
      end
   end

   logic do_step;
   // engine updates only in enhanced mode
   assign do_step = dma_cross & enhanced_mode_enable;

   // page registers; a processor write wins over a step
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pg0_ff <= `DPSR_RST_BYTE;
         pg5_ff <= `DPSR_RST_BYTE;
         pg6_ff <= `DPSR_RST_BYTE;
         pg7_ff <= `DPSR_RST_BYTE;
      end else begin
         if (io_wr && io_addr == `DPSR_OFF_CHAN0_PAGE) pg0_ff <= io_wdata;
         else if (do_step && dma_chan == DPSR_CH0) pg0_ff <= nxt_page;
         if (io_wr && io_addr == `DPSR_OFF_CHAN5_PAGE) pg5_ff <= io_wdata;
         else if (do_step && dma_chan == DPSR_CH5) pg5_ff <= nxt_page;
         if (io_wr && io_addr == `DPSR_OFF_CHAN6_PAGE) pg6_ff <= io_wdata;
         else if (do_step && dma_chan == DPSR_CH6) pg6_ff <= nxt_page;
         if (io_wr && io_addr == `DPSR_OFF_CHAN7_PAGE) pg7_ff <= io_wdata;
         else if (do_step && dma_chan == DPSR_CH7) pg7_ff <= nxt_page;
      end
   end

   // ************************************************************
   // processor read port
   // ************************************************************
   // reads answer from the stored copy only
   always_comb begin
      nxt_rdata = 8'h00;
      unique case (io_addr)
         `DPSR_OFF_SCRATCH1: nxt_rdata = scr1_ff;
         `DPSR_OFF_SCRATCH2: nxt_rdata = scr2_ff;
         `DPSR_OFF_SCRATCH3: nxt_rdata = scr3_ff;
         `DPSR_OFF_SCRATCH4: nxt_rdata = scr4_ff;
         `DPSR_OFF_CHAN0_PAGE: nxt_rdata = pg0_ff;
         // bit 0 reads back as written unless a byte-mode step has changed it
         `DPSR_OFF_CHAN5_PAGE: nxt_rdata = pg5_ff;
         `DPSR_OFF_CHAN6_PAGE: nxt_rdata = pg6_ff;
         `DPSR_OFF_CHAN7_PAGE: nxt_rdata = pg7_ff;
         default: nxt_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         io_rdata <= 8'h00;
         io_hit <= 1'b0;
      end else begin
         io_rdata <= io_rd ? nxt_rdata : 8'h00;
         io_hit <= (io_rd | io_wr) & (scr_hit | pg_hit);
      end
   end

   // ************************************************************
   // peripheral bus mirror
   // ************************************************************
   // one-cycle mirror of scratch writes; reads never start one
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ext_bus_wr <= 1'b0;
         ext_bus_addr <= 8'h00;
         ext_bus_data <= 8'h00;
      end else begin
         ext_bus_wr <= io_wr & scr_hit;
         if (io_wr && scr_hit) begin
            ext_bus_addr <= io_addr;
            ext_bus_data <= io_wdata;
         end
      end
   end

   // ************************************************************
   // DMA address formation
   // ************************************************************
   // registered, so the address trails the page and channel by one cycle
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         dma_addr <= 28'h0000000;
         dma_byte_mode <= 1'b1;
      end else begin
         dma_byte_mode <= cur_byte;
         if (cur_byte) begin
            // full page byte in byte mode
            dma_addr <= {dma_ext_page, cur_page, dma_low_addr};
         end else begin
            // word mode: page bits 7..1 then low field shifted up one
            dma_addr <= {dma_ext_page, cur_page[7:1], dma_low_addr, 1'b0};
         end
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   sequence s_scr_write;
      io_wr && scr_hit;
   endsequence

   chk_scratch_mirror: assert property (@(posedge sys_clk) disable iff (!nrst)
      s_scr_write |=> ext_bus_wr && ext_bus_data == $past(io_wdata))
      else $error("scratch write not mirrored");

   chk_read_no_bus: assert property (@(posedge sys_clk) disable iff (!nrst)
      (io_rd && !io_wr) |=> !ext_bus_wr)
      else $error("read started a bus cycle");

   chk_page_store: assert property (@(posedge sys_clk) disable iff (!nrst)
      (io_wr && io_addr == `DPSR_OFF_CHAN6_PAGE) |=> pg6_ff == $past(io_wdata))
      else $error("page write lost");

   chk_byte_addr: assert property (@(posedge sys_clk) disable iff (!nrst)
      (dma_chan == DPSR_CH0) |=> dma_addr[23:16] == $past(pg0_ff))
      else $error("byte address page wrong");

   chk_word_addr: assert property (@(posedge sys_clk) disable iff (!nrst)
      !cur_byte |=> dma_addr[16] == $past(dma_low_addr[15]) && !dma_byte_mode)
      else $error("word address bit 16 wrong");

   chk_bit0_back: assert property (@(posedge sys_clk) disable iff (!nrst)
      (io_wr && io_addr == `DPSR_OFF_CHAN5_PAGE) ##1 (io_rd && !io_wr &&
      io_addr == `DPSR_OFF_CHAN5_PAGE && !do_step) |=> io_rdata[0] == $past(io_wdata[0], 2))
      else $error("page bit 0 not read back");

   chk_width_sel: assert property (@(posedge sys_clk) disable iff (!nrst)
      (dma_chan != DPSR_CH0 && !enhanced_mode_enable) |=> !dma_byte_mode)
      else $error("byte mode without enhanced mode");

   chk_no_step: assert property (@(posedge sys_clk) disable iff (!nrst)
      (!enhanced_mode_enable && !io_wr) |=> $stable(pg0_ff) && $stable(pg7_ff))
      else $error("page moved outside enhanced mode");

   chk_step_carry: assert property (@(posedge sys_clk) disable iff (!nrst)
      (do_step && dma_chan == DPSR_CH7 && !cur_byte && !dma_down && !io_wr)
      |=> pg7_ff == $past(pg7_ff) + 8'h02)
      else $error("word carry wrong");

   chk_scratch_keep: assert property (@(posedge sys_clk) disable iff (!nrst)
      !io_wr |=> $stable(scr1_ff) && $stable(scr4_ff))
      else $error("scratch changed without write");
endmodule // dpsr_bank

/* File: testbench/dpsr_cpu_model.sv */
// processor core model issuing byte I/O cycles to the bank
`timescale 1ns/1ps
module dpsr_cpu_model (
   input wire logic sys_clk,
   output logic io_wr,
   output logic io_rd,
   output dpsr_pkg::dpsr_byte_t io_addr,
   output dpsr_pkg::dpsr_byte_t io_wdata
);
   import dpsr_pkg::*;
   initial begin
      io_wr = 1'h0;
      io_rd = 1'h0;
      io_addr = 8'h00;
      io_wdata = 8'h00;
   end
   // one-cycle strobe; idle bus shows inverted values so stale data never matches
   task automatic access(input logic wr, input dpsr_byte_t a, input dpsr_byte_t d);
      @(posedge sys_clk);
      io_wr <= wr;
      io_rd <= ~wr;
      io_addr <= a;
      io_wdata <= d;
      @(posedge sys_clk);
      io_wr <= 1'h0;
      io_rd <= 1'h0;
      io_addr <= ~a;
      io_wdata <= ~d;
   endtask
   // write then read of one address in consecutive cycles, no idle gap between
   task automatic write_read(input dpsr_byte_t a, input dpsr_byte_t d);
      @(posedge sys_clk);
      io_wr <= 1'h1;
      io_rd <= 1'h0;
      io_addr <= a;
      io_wdata <= d;
      @(posedge sys_clk);
      io_wr <= 1'h0;
      io_rd <= 1'h1;
      io_wdata <= ~d;
      @(posedge sys_clk);
      io_rd <= 1'h0;
      io_addr <= ~a;
   endtask
endmodule // dpsr_cpu_model

/* File: testbench/dpsr_bank_tb.sv */
// self-checking bench for the page and scratch bank
`timescale 1ns/1ps
module dpsr_bank_tb;
   import dpsr_pkg::*;
   logic sys_clk, nrst, io_wr, io_rd, io_hit, ext_bus_wr, enhanced_mode_enable;
   logic dma_cross, dma_down, dma_byte_mode;
   logic [2:0] alt_w;
   logic [3:0] dma_ext_page;
   dpsr_byte_t io_addr, io_wdata, io_rdata, ext_bus_addr, ext_bus_data;
   dpsr_chan_t dma_chan;
   dpsr_low_t dma_low_addr;
   dpsr_addr_t dma_addr;
   dpsr_byte_t mem [8];
   dpsr_byte_t rd_q [$];
   logic [15:0] ext_q [$];
   dpsr_byte_t st;
   int miscompares = 0;
   int total_checks = 0;
   // shadow index of the page byte for ch0, ch5, ch6, ch7
   int pix [4] = '{3, 7, 5, 6};

   dpsr_cpu_model u_dpsr_cpu_model (.sys_clk(sys_clk), .io_wr(io_wr), .io_rd(io_rd),
      .io_addr(io_addr), .io_wdata(io_wdata));
   dpsr_bank u_dpsr_bank (.sys_clk(sys_clk), .nrst(nrst), .io_wr(io_wr), .io_rd(io_rd),
      .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit),
      .ext_bus_wr(ext_bus_wr), .ext_bus_addr(ext_bus_addr), .ext_bus_data(ext_bus_data),
      .enhanced_mode_enable(enhanced_mode_enable), .chan5_alternate_width(alt_w[0]),
      .chan6_alternate_width(alt_w[1]), .chan7_alternate_width(alt_w[2]),
      .dma_chan(dma_chan), .dma_low_addr(dma_low_addr), .dma_ext_page(dma_ext_page),
      .dma_cross(dma_cross), .dma_down(dma_down), .dma_addr(dma_addr),
      .dma_byte_mode(dma_byte_mode));

   // ****************
   // checking
   // ****************
   task automatic note(input string m);
      miscompares++;
      $display("wrong value at %0t: %s", $time, m);
   endtask
   task automatic cmp_rd(input dpsr_byte_t exp);
      total_checks++;
      if (io_rdata !== exp) note("read byte");
   endtask
   task automatic cmp_ext(input logic [15:0] exp);
      total_checks++;
      if ({ext_bus_addr, ext_bus_data} !== exp) note("bus mirror");
   endtask
   task automatic cmp_dma(input dpsr_addr_t exp, input logic bm);
      total_checks++;
      if (dma_addr !== exp || dma_byte_mode !== bm) note("dma address");
   endtask
   task automatic final_report();
      $display("checks %0d, miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   function automatic logic exp_bm();
      return dma_chan == DPSR_CH0 || (enhanced_mode_enable && alt_w[dma_chan - 1]);
   endfunction
   function automatic dpsr_addr_t exp_addr(input logic bm);
      dpsr_byte_t p;
      p = mem[pix[dma_chan]];
      return bm ? {dma_ext_page, p, dma_low_addr} : {dma_ext_page, p[7:1], dma_low_addr, 1'h0};
   endfunction
   // every mapped access leaves one note; scratch writes leave a mirror note
   task automatic do_acc(input logic wr, input int i, input dpsr_byte_t d);
      if (wr) mem[i] = d;
      rd_q.push_back(wr ? 8'h00 : mem[i]);
      if (wr && i inside {0, 1, 2, 4}) ext_q.push_back({8'h84 + 8'(i), d});
      u_dpsr_cpu_model.access(wr, 8'h84 + 8'(i), d);
   endtask
   always @(negedge sys_clk) begin
      if (io_hit === 1'h1) begin
         if (rd_q.size() == 0) note("unexpected hit");
         else cmp_rd(rd_q.pop_front());
      end
      if (ext_bus_wr === 1'h1) begin
         if (ext_q.size() == 0) note("unexpected mirror");
         else cmp_ext(ext_q.pop_front());
      end
   end

   // ****************
   // stimulus
   // ****************
   initial begin
      sys_clk = 1'h0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      note("timeout");
      final_report();
   end
   initial begin
      void'($urandom(32'h14C23C34));
      {nrst, enhanced_mode_enable, alt_w, dma_cross, dma_down, dma_ext_page} = '0;
      dma_chan = DPSR_CH0;
      dma_low_addr = 16'h0000;
      foreach (mem[i]) mem[i] = 8'h00;
      repeat (8) @(posedge sys_clk);
      nrst <= 1'h1;
      for (int i = 0; i < 8; i++) do_acc(1'h0, i, 8'h00);
      for (int i = 0; i < 8; i++) do_acc(1'h1, i, 8'($urandom));
      for (int i = 0; i < 8; i++) do_acc(1'h0, i, 8'h00);
      // back-to-back write and read of the channel 5 page
      st = 8'($urandom);
      mem[7] = st;
      rd_q.push_back(8'h00);
      rd_q.push_back(st);
      u_dpsr_cpu_model.write_read(8'h8B, st);
      u_dpsr_cpu_model.access(1'h0, 8'h83, 8'h00);
      u_dpsr_cpu_model.access(1'h1, 8'h8C, 8'h5A);
      for (int k = 0; k < 16; k++) begin
         @(posedge sys_clk);
         dma_chan <= dpsr_chan_t'(k[1:0]);
         enhanced_mode_enable <= k[2];
         alt_w <= {3{k[3]}};
         dma_low_addr <= 16'($urandom);
         dma_ext_page <= 4'($urandom);
         repeat (2) @(posedge sys_clk);
         #1 cmp_dma(exp_addr(exp_bm()), exp_bm());
      end
      // steps up and down in both widths; none without enhanced mode
      for (int k = 0; k < 8; k++) begin
         @(posedge sys_clk);
         dma_chan <= dpsr_chan_t'(k[1:0]);
         enhanced_mode_enable <= (k != 2);
         dma_down <= k[2];
         alt_w <= 3'h1;
         @(posedge sys_clk);
         dma_cross <= 1'h1;
         @(posedge sys_clk);
         dma_cross <= 1'h0;
         st = exp_bm() ? 8'h01 : 8'h02;
         if (enhanced_mode_enable) mem[pix[k[1:0]]] += dma_down ? -st : st;
         repeat (2) @(posedge sys_clk);
         #1 cmp_dma(exp_addr(exp_bm()), exp_bm());
         do_acc(1'h0, pix[k[1:0]], 8'h00);
      end
      fork
         do_acc(1'h1, 6, 8'h3C);
         begin
            @(posedge sys_clk);
            dma_cross <= 1'h1;
            @(posedge sys_clk);
            dma_cross <= 1'h0;
         end
      join
      do_acc(1'h0, 6, 8'h00);
      for (int n = 0; n < 10 && rd_q.size() + ext_q.size() > 0; n++) @(posedge sys_clk);
      if (rd_q.size() + ext_q.size() > 0) note("results missing");
      final_report();
   end
endmodule // dpsr_bank_tb
